// file: core/ulpc_pkg.sv
// Shared constants and types of the uplink closed-loop power control block.
// Assumes every user of it names its items as ulpc_pkg::name.
package ulpc_pkg;

	// Two-bit power control command codes as received from the network.
	localparam logic [1:0] TPC_DN_L = 2'h0;
	localparam logic [1:0] TPC_DN_S = 2'h1;
	localparam logic [1:0] TPC_UP_S = 2'h2;
	localparam logic [1:0] TPC_UP_L = 2'h3;

	// Fraction bits of the alpha and kappa factors.
	localparam int FRAC_W = 8;

	// Values after reset.
	localparam int PWR_RESET  = 0;
	localparam int STEP_RESET = 0;

	// Signed command value, two's complement in three bits.
	typedef enum logic [2:0] {
		ULPC_CMD_M2 = 3'h6,
		ULPC_CMD_M1 = 3'h7,
		ULPC_CMD_P1 = 3'h1,
		ULPC_CMD_P2 = 3'h2
	} ulpc_cmd_type;

endpackage

// file: core/ulpc_if.sv
// Carrier of the combined command from the combiner to the power loop.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface ulpc_if;
	logic                  done;
	ulpc_pkg::ulpc_cmd_type cmd;

	modport src (output done, output cmd);
	modport snk (input done, input cmd);
endinterface

// file: core/ulpc_comb.sv
// Command decoder and soft-handover combiner.
// Assumes link inputs come from same-clock demodulator logic.
`timescale 1ns/1ps
module ulpc_comb #(
	parameter int NUM_LINKS = 4,
	parameter int NUM_SETS  = 4,
	parameter int SOFT_W    = 8
)(
	// Clock and reset.
	input  wire logic                          core_clk,
	input  wire logic                          rst,
	// Received commands.
	input  wire logic                          tpc_valid,
	input  wire logic                          in_soft_handover,
	input  wire logic [NUM_LINKS-1:0]          link_valid,
	input  wire logic [NUM_LINKS*$clog2(NUM_SETS>1?NUM_SETS:2)-1:0] link_set,
	input  wire logic [NUM_LINKS*SOFT_W-1:0]   link_soft_hi,
	input  wire logic [NUM_LINKS*SOFT_W-1:0]   link_soft_lo,
	input  wire logic [SOFT_W-1:0]             soft_thresh,
	// Combined command.
	ulpc_if.src                                res
);
	localparam int SET_W = (NUM_SETS > 1) ? $clog2(NUM_SETS) : 1;
	localparam int ACC_W = SOFT_W + $clog2(NUM_LINKS) + 1;
	localparam int CNT_W = $clog2(NUM_SETS + 1);

	if (NUM_LINKS < 1 || NUM_SETS < 1 || SOFT_W < 2) begin : g_chk
		$error("ulpc_comb: unsupported parameters");
	end

	function automatic logic signed [ACC_W-1:0] ext(
		input logic [SOFT_W-1:0] v);
		return {{(ACC_W-SOFT_W){v[SOFT_W-1]}}, v};
	endfunction

	// Returns {hard bit, reliable}; a positive soft value means bit one.
	function automatic logic [1:0] soft_dec(
		input logic signed [ACC_W-1:0] v,
		input logic [SOFT_W-1:0]       thr);
		logic [ACC_W-1:0] mag;
		mag = v[ACC_W-1] ? ACC_W'(-v) : ACC_W'(v);
		return {~v[ACC_W-1], mag >= ACC_W'(thr)};
	endfunction

	logic signed [ACC_W-1:0] acc_hi [NUM_SETS];
	logic signed [ACC_W-1:0] acc_lo [NUM_SETS];
	logic [NUM_SETS-1:0]     act;
	logic [CNT_W-1:0]        n_act;
	logic [CNT_W-1:0]        n_up;
	logic                    any_00;
	logic                    all_11;
	logic [1:0]              dh;
	logic [1:0]              dl;
	logic [1:0]              hard;
	ulpc_pkg::ulpc_cmd_type  cmd_reg;
	ulpc_pkg::ulpc_cmd_type  cmd_next;
	logic                    done_reg;
	logic                    done_next;

	always_comb begin
		n_act = '0;
		n_up = '0;
		any_00 = 1'b0;
		all_11 = 1'b1;
		dh = '0;
		dl = '0;
		hard = {~link_soft_hi[SOFT_W-1], ~link_soft_lo[SOFT_W-1]};
		for (int s = 0; s < NUM_SETS; s++) begin
			acc_hi[s] = '0;
			acc_lo[s] = '0;
			act[s] = 1'b0;
			for (int l = 0; l < NUM_LINKS; l++) begin
				if (link_valid[l] &&
				    link_set[l*SET_W +: SET_W] == SET_W'(s)) begin
					acc_hi[s] = acc_hi[s] + ext(link_soft_hi[l*SOFT_W +: SOFT_W]);
					acc_lo[s] = acc_lo[s] + ext(link_soft_lo[l*SOFT_W +: SOFT_W]);
					act[s] = 1'b1;
				end
			end
		end
		for (int s = 0; s < NUM_SETS; s++) begin
			dh = soft_dec(acc_hi[s], soft_thresh);
			dl = soft_dec(acc_lo[s], soft_thresh);
			if (act[s]) begin
				n_act = n_act + CNT_W'(1);
				if (dh[1])
					n_up = n_up + CNT_W'(1);
				if (dh == 2'h1 && dl == 2'h1)
					any_00 = 1'b1;
				if (!(dh == 2'h3 && dl == 2'h3))
					all_11 = 1'b0;
			end
		end
		if (n_act == '0)
			all_11 = 1'b0;

		done_next = 1'b0;
		cmd_next = cmd_reg;
		if (tpc_valid && !in_soft_handover) begin
			done_next = 1'b1;
			unique case (hard)
				ulpc_pkg::TPC_DN_L: cmd_next = ulpc_pkg::ULPC_CMD_M2;
				ulpc_pkg::TPC_DN_S: cmd_next = ulpc_pkg::ULPC_CMD_M1;
				ulpc_pkg::TPC_UP_S: cmd_next = ulpc_pkg::ULPC_CMD_P1;
				ulpc_pkg::TPC_UP_L: cmd_next = ulpc_pkg::ULPC_CMD_P2;
			endcase
		end else if (tpc_valid && n_act != '0) begin
			done_next = 1'b1;
			if (any_00)
				cmd_next = ulpc_pkg::ULPC_CMD_M2;
			else if (all_11)
				cmd_next = ulpc_pkg::ULPC_CMD_P2;
			else if ({n_up, 1'b0} > {1'b0, n_act})
				cmd_next = ulpc_pkg::ULPC_CMD_P1;
			else
				cmd_next = ulpc_pkg::ULPC_CMD_M1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			cmd_reg <= ulpc_pkg::ULPC_CMD_M1;
			done_reg <= 1'b0;
		end else begin
			cmd_reg <= cmd_next;
			done_reg <= done_next;
		end
	end

	assign res.done = done_reg;
	assign res.cmd = cmd_reg;

endmodule

// file: core/ulpc_top.sv
// Uplink inner-loop power control of the mobile terminal.
// Assumes all inputs come from logic on core_clk, so none is synchronised,
// and that frame-start strobes are one-cycle pulses.
`timescale 1ns/1ps
// Notes on behaviour
// - DPCCH and DPDCH move together, fixed offset; DPDCH is clamped to min_power..max_power.
// - Adjust upward only below maximum power.
// - Apply dB step only at frame start.
// - Alpha from higher layers, same per beam.
// - Normal step is current minus alpha previous.
// - Soft handover step is kappa times current.
// - Command value maps to signed step size.
// - Two-bit command decodes to signed value.
// - Merge links per set, then across sets.
// - Soft decisions combine into one value.
// - All reliable up gives 2; any reliable down -2.
// - Combiner probabilities meet the stated bounds.
// - PCPCH uses same step, at message start.
module ulpc_top #(
	parameter int NUM_LINKS = 4,
	parameter int NUM_SETS  = 4,
	parameter int SOFT_W    = 8,
	parameter int STEP_W    = 8,
	parameter int PWR_W     = 12
)(
	// Clock and reset.
	input  wire logic                          core_clk,
	input  wire logic                          rst,
	// Received power control commands.
	input  wire logic                          tpc_valid,
	input  wire logic [NUM_LINKS-1:0]          link_valid,
	input  wire logic [NUM_LINKS*$clog2(NUM_SETS>1?NUM_SETS:2)-1:0] link_set,
	input  wire logic [NUM_LINKS*SOFT_W-1:0]   link_soft_hi,
	input  wire logic [NUM_LINKS*SOFT_W-1:0]   link_soft_lo,
	input  wire logic [SOFT_W-1:0]             soft_thresh,
	// Higher-layer configuration.
	input  wire logic                          in_soft_handover,
	input  wire logic [STEP_W-1:0]             step_small,
	input  wire logic [STEP_W-1:0]             step_large,
	input  wire logic [ulpc_pkg::FRAC_W-1:0]   alpha,
	input  wire logic [ulpc_pkg::FRAC_W-1:0]   kappa,
	input  wire logic signed [PWR_W-1:0]       dpdch_offset,
	input  wire logic signed [PWR_W-1:0]       max_power,
	input  wire logic signed [PWR_W-1:0]       min_power,
	// Frame timing.
	input  wire logic                          dpcch_frame_start,
	input  wire logic                          pcpch_active,
	input  wire logic                          pcpch_msg_start,
	// Power levels and status.
	output logic signed [PWR_W-1:0]            dpcch_power,
	output logic signed [PWR_W-1:0]            dpdch_power,
	output logic signed [PWR_W-1:0]            pcpch_cp_power,
	output logic signed [STEP_W+1:0]           delta_dpcch,
	output logic [2:0]                         last_cmd,
	output logic                               at_max_power
);
	localparam int SET_W  = (NUM_SETS > 1) ? $clog2(NUM_SETS) : 1;
	localparam int FACT_W = ulpc_pkg::FRAC_W;
	localparam int SW     = STEP_W + 1;
	localparam int DW     = STEP_W + 2;

	if (PWR_W < DW + 1 || STEP_W < 2 || NUM_SETS < 1) begin : g_chk
		$error("ulpc_top: unsupported parameters");
	end

	function automatic logic signed [SW-1:0] step_of(
		input ulpc_pkg::ulpc_cmd_type c,
		input logic [STEP_W-1:0]      sm,
		input logic [STEP_W-1:0]      lg);
		logic signed [SW-1:0] s;
		logic signed [SW-1:0] l;
		s = {1'b0, sm};
		l = {1'b0, lg};
		unique case (c)
			ulpc_pkg::ULPC_CMD_M2: return -l;
			ulpc_pkg::ULPC_CMD_M1: return -s;
			ulpc_pkg::ULPC_CMD_P1: return s;
			ulpc_pkg::ULPC_CMD_P2: return l;
			default:               return -s;
		endcase
	endfunction

	// Multiplies a step by an unsigned fraction below one.
	function automatic logic signed [SW-1:0] scale(
		input logic signed [SW-1:0] s,
		input logic [FACT_W-1:0]    f);
		logic signed [SW+FACT_W:0] p;
		p = s * $signed({1'b0, f});
		return p[FACT_W+SW-1:FACT_W];
	endfunction

	// Saturating sum into the power range.
	function automatic logic signed [PWR_W-1:0] sat_add(
		input logic signed [PWR_W-1:0] a,
		input logic signed [PWR_W-1:0] b,
		input logic signed [PWR_W-1:0] lo,
		input logic signed [PWR_W-1:0] hi);
		logic signed [PWR_W:0] t;
		t = {a[PWR_W-1], a} + {b[PWR_W-1], b};
		if (t > $signed({hi[PWR_W-1], hi}))
			return hi;
		if (t < $signed({lo[PWR_W-1], lo}))
			return lo;
		return t[PWR_W-1:0];
	endfunction

	// One closed-loop step; at the ceiling only downward steps act.
	function automatic logic signed [PWR_W-1:0] apply(
		input logic signed [PWR_W-1:0] p,
		input logic signed [DW-1:0]    d,
		input logic signed [PWR_W-1:0] lo,
		input logic signed [PWR_W-1:0] hi);
		logic signed [PWR_W-1:0] dx;
		dx = {{(PWR_W-DW){d[DW-1]}}, d};
		if (p >= hi && d > 0)
			return p;
		return sat_add(p, dx, lo, hi);
	endfunction

	ulpc_if u_if ();

	ulpc_comb #(
		.NUM_LINKS (NUM_LINKS),
		.NUM_SETS  (NUM_SETS),
		.SOFT_W    (SOFT_W)
	) u_comb (
		.core_clk         (core_clk),
		.rst              (rst),
		.tpc_valid        (tpc_valid),
		.in_soft_handover (in_soft_handover),
		.link_valid       (link_valid),
		.link_set         (link_set),
		.link_soft_hi     (link_soft_hi),
		.link_soft_lo     (link_soft_lo),
		.soft_thresh      (soft_thresh),
		.res              (u_if)
	);

	logic signed [SW-1:0]    prev_step_reg;
	logic signed [SW-1:0]    prev_step_next;
	logic signed [DW-1:0]    pend_delta_reg;
	logic signed [DW-1:0]    pend_delta_next;
	logic                    pend_dpcch_reg;
	logic                    pend_dpcch_next;
	logic                    pend_pcpch_reg;
	logic                    pend_pcpch_next;
	logic signed [PWR_W-1:0] dpcch_pwr_reg;
	logic signed [PWR_W-1:0] dpcch_pwr_next;
	logic signed [PWR_W-1:0] dpdch_pwr_reg;
	logic signed [PWR_W-1:0] dpdch_pwr_next;
	logic signed [PWR_W-1:0] pcpch_pwr_reg;
	logic signed [PWR_W-1:0] pcpch_pwr_next;
	logic [2:0]              last_cmd_reg;
	logic [2:0]              last_cmd_next;
	logic                    at_max_reg;
	logic                    at_max_next;
	logic signed [SW-1:0]    step_cur;
	logic signed [SW-1:0]    step_red;

	always_comb begin
		step_cur = step_of(u_if.cmd, step_small, step_large);
		prev_step_next = prev_step_reg;
		pend_delta_next = pend_delta_reg;
		last_cmd_next = last_cmd_reg;
		pend_dpcch_next = pend_dpcch_reg;
		pend_pcpch_next = pend_pcpch_reg;
		dpcch_pwr_next = dpcch_pwr_reg;
		pcpch_pwr_next = pcpch_pwr_reg;
		step_red = scale(in_soft_handover ? step_cur : prev_step_reg,
		                 in_soft_handover ? kappa : alpha);

		// A frame start consumes the pending step before a new one lands.
		// apply at frame start
		if (dpcch_frame_start) begin
			pend_dpcch_next = 1'b0;
			if (pend_dpcch_reg)
				dpcch_pwr_next = apply(dpcch_pwr_reg, pend_delta_reg,
				                       min_power, max_power);
		end
		if (pcpch_msg_start) begin
			pend_pcpch_next = 1'b0;
			if (pend_pcpch_reg)
				pcpch_pwr_next = apply(pcpch_pwr_reg, pend_delta_reg,
				                       min_power, max_power);
		end

		if (u_if.done) begin
			prev_step_next = step_cur;
			last_cmd_next = u_if.cmd;
			pend_dpcch_next = 1'b1;
			pend_pcpch_next = pcpch_active;
			if (in_soft_handover)
				pend_delta_next = {step_red[SW-1], step_red};
			else
				pend_delta_next = {step_cur[SW-1], step_cur} -
				                  {step_red[SW-1], step_red};
		end

		dpdch_pwr_next = sat_add(dpcch_pwr_next, dpdch_offset,
		                         min_power, max_power);
		at_max_next = dpcch_pwr_next >= max_power;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			prev_step_reg <= SW'(ulpc_pkg::STEP_RESET);
			pend_delta_reg <= DW'(ulpc_pkg::STEP_RESET);
			pend_dpcch_reg <= 1'b0;
			pend_pcpch_reg <= 1'b0;
			dpcch_pwr_reg <= PWR_W'(ulpc_pkg::PWR_RESET);
			dpdch_pwr_reg <= PWR_W'(ulpc_pkg::PWR_RESET);
			pcpch_pwr_reg <= PWR_W'(ulpc_pkg::PWR_RESET);
			last_cmd_reg <= ulpc_pkg::ULPC_CMD_M1;
			at_max_reg <= 1'b0;
		end else begin
			prev_step_reg <= prev_step_next;
			pend_delta_reg <= pend_delta_next;
			pend_dpcch_reg <= pend_dpcch_next;
			pend_pcpch_reg <= pend_pcpch_next;
			dpcch_pwr_reg <= dpcch_pwr_next;
			dpdch_pwr_reg <= dpdch_pwr_next;
			pcpch_pwr_reg <= pcpch_pwr_next;
			last_cmd_reg <= last_cmd_next;
			at_max_reg <= at_max_next;
		end
	end

	assign dpcch_power = dpcch_pwr_reg;
	assign dpdch_power = dpdch_pwr_reg;
	assign pcpch_cp_power = pcpch_pwr_reg;
	assign delta_dpcch = pend_delta_reg;
	assign last_cmd = last_cmd_reg;
	assign at_max_power = at_max_reg;

endmodule

// file: tb/ulpc_chk_checker.sv
// Concurrent checks on the ports of the power control top.
// Assumes it is bound into ulpc_top and sees only its ports.
`timescale 1ns/1ps
module ulpc_chk #(
	parameter int NUM_LINKS = 4,
	parameter int SOFT_W    = 8,
	parameter int STEP_W    = 8,
	parameter int PWR_W     = 12
)(
	// Clock, reset and inputs.
	input wire logic				core_clk,
	input wire logic				rst,
	input wire logic				tpc_valid,
	input wire logic				in_soft_handover,
	input wire logic [NUM_LINKS*SOFT_W-1:0]	link_soft_hi,
	input wire logic [NUM_LINKS*SOFT_W-1:0]	link_soft_lo,
	input wire logic				dpcch_frame_start,
	input wire logic				pcpch_msg_start,
	input wire logic signed [PWR_W-1:0]	dpdch_offset,
	input wire logic signed [PWR_W-1:0]	max_power,
	input wire logic signed [PWR_W-1:0]	min_power,
	// Outputs.
	input wire logic signed [PWR_W-1:0]	dpcch_power,
	input wire logic signed [PWR_W-1:0]	dpdch_power,
	input wire logic signed [PWR_W-1:0]	pcpch_cp_power,
	input wire logic signed [STEP_W+1:0]	delta_dpcch,
	input wire logic [2:0]			last_cmd,
	input wire logic				at_max_power
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	logic signed [PWR_W:0]	dpdch_sum;
	assign dpdch_sum = dpcch_power + dpdch_offset;

	a_dec_up: assert property (tpc_valid && !in_soft_handover &&
		!link_soft_hi[SOFT_W-1] && !link_soft_lo[SOFT_W-1]
		|-> ##2 last_cmd == 3'h2) else $error("code 11 not +2");
	a_dec_down: assert property (tpc_valid && !in_soft_handover &&
		link_soft_hi[SOFT_W-1] && link_soft_lo[SOFT_W-1]
		|-> ##2 last_cmd == 3'h6) else $error("code 00 not -2");
	a_frame_hold: assert property (!dpcch_frame_start
		|=> $stable(dpcch_power)) else $error("power moved mid frame");
	a_dpdch_track: assert property ($changed(dpcch_power) &&
		dpdch_sum <= max_power && dpdch_sum >= min_power
		|-> dpdch_power == dpdch_sum) else $error("offset lost");
	a_clamp_range: assert property ($changed(dpcch_power) |->
		dpcch_power <= $past(max_power) && dpcch_power >= $past(min_power))
		else $error("power out of range");
	a_max_flag: assert property (at_max_power ==
		(dpcch_power >= $past(max_power))) else $error("bad max flag");
	a_cmd_legal: assert property (last_cmd inside
		{3'h6, 3'h7, 3'h1, 3'h2}) else $error("illegal command");
	a_delta_hold: assert property (!tpc_valid ##1 !tpc_valid
		|=> $stable(delta_dpcch) && $stable(last_cmd))
		else $error("step moved without command");
	a_pcpch_hold: assert property (!pcpch_msg_start
		|=> $stable(pcpch_cp_power)) else $error("control part moved");
	cover property (tpc_valid && in_soft_handover);
	cover property (dpcch_frame_start ##1 at_max_power);
	cover property ($changed(pcpch_cp_power));
endmodule
bind ulpc_top ulpc_chk #(.NUM_LINKS(NUM_LINKS), .SOFT_W(SOFT_W),
	.STEP_W(STEP_W), .PWR_W(PWR_W)) i_ulpc_chk (.*);

// file: tb/ulpc_net.sv
// Network side model: shows one command as soft values per request.
// Assumes the bench calls send from a single process.
`timescale 1ns/1ps
module ulpc_net (
	// Clock.
	input wire logic	core_clk,
	// Command lines toward the terminal.
	output logic		tpc_valid,
	output logic [31:0]	link_soft_hi,
	output logic [31:0]	link_soft_lo
);
	logic		req = 1'b0;
	logic [7:0]	codes;
	logic [7:0]	mag;
	logic [7:0]	junk = 8'h5A;
	int		hist[3] = '{0, 0, 0};
	localparam int ERR_THR = 16;
	// one command: shown for one cycle, junk otherwise.
	always @(negedge core_clk) begin
		tpc_valid <= req;
		junk <= junk + 8'h3B;
		for (int l = 0; l < 4; l++) begin
			// signed steps: a one bit gives a positive value.
			link_soft_hi[l*8+:8] <= !req ? junk : codes[2*l+1] ? mag : -mag;
			link_soft_lo[l*8+:8] <= !req ? ~junk : codes[2*l] ? mag : -mag;
		end
	end
	task automatic send(input logic [7:0] c, input logic [7:0] m);
		@(posedge core_clk);
		codes = c;
		mag = m;
		req = 1'b1;
		@(posedge core_clk);
		req = 1'b0;
	endtask
	// step history: loop delay of two frames plus one.
	task automatic push(input int s);
		hist[2] = hist[1];
		hist[1] = hist[0];
		hist[0] = s;
	endtask
	// compensated error; the indicator is one in soft handover.
	function automatic int comp_err(input int err, input logic sho,
		input int a);
		int sum;
		sum = 0;
		for (int k = 0; k < 2; k++)
			sum += hist[k] - ((a * hist[k+1]) >>> 8);
		return sho ? err + sum : err;
	endfunction
	// sign picks direction, size picks the step.
	function automatic logic [1:0] pick(input int e);
		if (e < 0)
			return -e < ERR_THR ? 2'h2 : 2'h3;
		return e < ERR_THR ? 2'h1 : 2'h0;
	endfunction
endmodule

// file: tb/ulpc_top_tb.sv
// Self-checking bench of the uplink power control top.
// Assumes the network model drives the command lines.
`timescale 1ns/1ps
module ulpc_top_tb;
	logic			core_clk = 1'b0;
	logic			rst = 1'b1;
	logic			in_soft_handover = 1'b0;
	logic [3:0]		link_valid = 4'hF;
	logic [7:0]		link_set = 8'hE4;
	logic [7:0]		soft_thresh = 8'h10;
	logic [7:0]		step_small = 8'h04;
	logic [7:0]		step_large = 8'h10;
	logic [7:0]		alpha = 8'h80;
	logic [7:0]		kappa = 8'hC0;
	logic signed [11:0]	dpdch_offset = 12'h010;
	logic signed [11:0]	max_power = 12'h040;
	logic signed [11:0]	min_power = 12'hFC0;
	logic			dpcch_frame_start = 1'b0;
	logic			pcpch_active = 1'b1;
	logic			pcpch_msg_start = 1'b0;
	logic			tpc_valid;
	logic [31:0]		link_soft_hi;
	logic [31:0]		link_soft_lo;
	logic signed [11:0]	dpcch_power;
	logic signed [11:0]	dpdch_power;
	logic signed [11:0]	pcpch_cp_power;
	logic signed [9:0]	delta_dpcch;
	logic [2:0]		last_cmd;
	logic			at_max_power;
	logic [2:0]		vpipe = 3'h0;
	logic [12:0]		notes[$];
	int			miscompares = 0;
	int			num_checks = 0;
	int			prev_step = 0;
	int			last_d = 0;
	int			exp_pw = 0;
	int			pend = 0;
	int			pend_cp = 0;
	int			exp_cp = 0;
	int			last_v = 0;
	int			seed = 32'hf6a6;
	int			cmd_v[4] = '{-2, -1, 1, 2};

	always #2 core_clk = ~core_clk;

	ulpc_net i_ulpc_net (.core_clk, .tpc_valid, .link_soft_hi, .link_soft_lo);
	ulpc_top i_ulpc_top (.core_clk, .rst, .tpc_valid, .link_valid, .link_set,
		.link_soft_hi, .link_soft_lo, .soft_thresh, .in_soft_handover,
		.step_small, .step_large, .alpha, .kappa, .dpdch_offset, .max_power,
		.min_power, .dpcch_frame_start, .pcpch_active, .pcpch_msg_start,
		.dpcch_power, .dpdch_power, .pcpch_cp_power, .delta_dpcch, .last_cmd,
		.at_max_power);

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_cmd(input logic [12:0] got, input logic [12:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR at %0t: command got %h expected %h", $time,
				got, exp);
		end
	endtask

	// Next level after one step, with the ceiling rule and clamping.
	function automatic int next_pw(input int p, input int d);
		int t;
		t = (p >= max_power && d > 0) ? p : p + d;
		return t > max_power ? max_power : t < min_power ? min_power : t;
	endfunction

	task automatic results();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Notes the expected command value and step, then sends the command.
	task automatic cmd(input logic [7:0] codes, input int v);
		int s;
		s = v > 1 ? int'(step_large) : v > 0 ? int'(step_small) :
			v < -1 ? -int'(step_large) : -int'(step_small);
		last_d = in_soft_handover ? (int'(kappa) * s) >>> 8 :
			s - ((int'(alpha) * prev_step) >>> 8);
		prev_step = s;
		pend = 1;
		pend_cp = pcpch_active;
		last_v = v;
		i_ulpc_net.push(s);
		notes.push_back({v[2:0], last_d[9:0]});
		i_ulpc_net.send(codes, 8'h20 + 8'($random(seed) & 8'h3F));
	endtask

	// The network model turns an error into a code sent on every link.
	task automatic track(input int err);
		logic [1:0] c;
		c = i_ulpc_net.pick(i_ulpc_net.comp_err(err, in_soft_handover,
			int'(alpha)));
		cmd({4{c}}, cmd_v[c]);
	endtask

	// A pending step is applied once; an upward one is dropped at maximum.
	task automatic frame();
		repeat (2) @(negedge core_clk);
		if (pend == 1) begin
			exp_pw = next_pw(exp_pw, last_d);
		end
		if (pend_cp == 1) begin
			exp_cp = next_pw(exp_cp, last_d);
		end
		pend = 0;
		pend_cp = 0;
		dpcch_frame_start = 1'b1;
		pcpch_msg_start = 1'b1;
		@(negedge core_clk);
		dpcch_frame_start = 1'b0;
		pcpch_msg_start = 1'b0;
		@(negedge core_clk);
		chk(dpcch_power, exp_pw);
		chk(dpdch_power, exp_pw + 16 > max_power ? max_power : exp_pw + 16);
		chk(pcpch_cp_power, exp_cp);
		chk(at_max_power, exp_pw >= max_power);
	endtask

	// Refused soft-handover commands leave no result to compare.
	always @(posedge core_clk) begin
		vpipe <= {vpipe[1:0],
			tpc_valid && (!in_soft_handover || link_valid != 4'h0)};
	end
	always @(negedge core_clk) begin
		if (vpipe[2]) begin
			chk_cmd({last_cmd, delta_dpcch}, notes.pop_front());
		end
	end

	initial begin
		logic [1:0]	c;
		repeat (16) @(posedge core_clk);
		@(negedge core_clk);
		rst = 1'b0;
		for (int i = 0; i < 12; i++) begin
			c = i < 4 ? i[1:0] : 2'($random(seed));
			cmd({6'($random(seed)), c}, cmd_v[c]);
		end
		for (int i = 0; i < 3; i++) begin
			track($random(seed) % 40);
		end
		frame();
		frame();
		for (int i = 0; i < 7; i++) begin
			cmd(8'hFF, 2);
			frame();
		end
		cmd(8'h00, -2);
		frame();
		in_soft_handover = 1'b1;
		cmd(8'hFF, 2);
		cmd(8'hF3, -2);
		cmd(8'hAA, 1);
		cmd(8'h55, -1);
		@(negedge core_clk);
		link_set = 8'hE0;
		pcpch_active = 1'b0;
		cmd(8'hFC, 1);
		for (int i = 0; i < 3; i++) begin
			track($random(seed) % 40);
		end
		frame();
		@(negedge core_clk);
		link_valid = 4'h0;
		i_ulpc_net.send(8'h00, 8'h40);
		repeat (4) @(negedge core_clk);
		chk_cmd({last_cmd, delta_dpcch},
			{last_v[2:0], last_d[9:0]});
		frame();
		for (int k = 0; k < 20 && notes.size() > 0; k++) @(negedge core_clk);
		if (notes.size() > 0) begin
			miscompares++;
			$display("ERROR at %0t: results missing", $time);
		end
		results();
	end

	initial begin
		#100000;
		miscompares++;
		$display("ERROR at %0t: timeout", $time);
		results();
	end
endmodule
